// [hdl/flash_protect_boot_map.sv]
// flash protection, option bits, boot map and write buffer control
// assumes apb master on pclk, wipe pin already debounced and synchronous to pclk
// ==========================================================
// How it works
// - single-bank build: one bank of 2048 pages of 256 bytes
// - dual-bank build: two banks of 1024 pages of 256 bytes
// - 128-byte write buffer filled through 32-bit words before programming
// - array read width selectable: 128 bits fast or 64 bits low current
// - sixteen lock regions of 128 pages, one lock bit each
// - program or erase on a locked region aborts and raises an event
// - set-lock protects the addressed region, clear-lock removes it
// - wipe pin clears every lock bit
// - security bit blocks debug and fast programming access to everything
// - security set only by command; cleared only by wipe then full erase
// - calibration bits and unique id are read-only and survive wipe
// - sram at 0x2000_0000, bit-band alias 0x2200_0000 to 0x23ff_ffff
// - boot rom always mapped at 0x0080_0000
// - boot at 0x0: flash if option bit 1 set, else rom
// - wipe clears option bit 1 so next boot is from rom
// - dual-bank: option bit 2 is a bank-select bit the boot map ignores; wipe clears it
// - two option bits single-bank, three dual-bank, set and clear commands
// - one controller; never program both banks nor read both at once
// - dual-bank: first 256 kbytes bank 0, next 256 kbytes bank 1
// - descriptor command streams six organisation words into result; only the last, pages per region, remains
module flash_protect_boot_map #(
   parameter bit DUAL_BANK = 1'b1
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // wipe pin, level
   input wire logic wipe_pin,
   // external access requests
   input wire logic debug_req,
   input wire logic fast_prog_req,
   input wire logic [31:0] sys_addr,
   // array read requests per bank
   input wire logic [1:0] bank_read_req,
   // status outputs
   output logic debug_grant,
   output logic fast_prog_grant,
   output logic [2:0] sys_target, // 0 none,1 sram,2 bitband,3 rom,4 flash
   output logic [1:0] bank_read_grant,
   output logic [1:0] bank_prog_active,
   output logic [1:0] read_width_sel, // 01 = 64 bit, 10 = 128 bit
   output logic cmd_done_pulse,
   output logic lock_abort_pulse
);
   // ==========================================================
   // state
   typedef enum {ST_IDLE, ST_EXEC, ST_DESC} seq_e;
   seq_e state_reg, state_next;
   flash_pkg::mode_s mode_reg;
   logic [15:0] locks_reg;
   logic [2:0] opts_reg;
   logic lock_err_reg, cmd_err_reg, wiped_reg;
   logic [7:0] op_reg;
   logic [15:0] arg_reg;
   logic [31:0] result_reg;
   logic [2:0] desc_idx_reg;
   logic [31:0] wbuf [flash_pkg::WBUF_WORDS];
   logic [1:0] prog_bank_reg;

   // ==========================================================
   // apb decode
   wire logic acc = psel & penable;
   wire logic wr = acc & pwrite;
   wire logic rd = acc & ~pwrite;
   wire logic in_wbuf = paddr[11:7] == flash_pkg::OFS_WBUF[11:7];
   wire logic [4:0] wb_idx = paddr[6:2];
   wire logic busy = state_reg != ST_IDLE;
   wire logic wr_cmd = wr & (paddr == flash_pkg::OFS_CMD) & ~busy;
   wire logic rd_status = rd & (paddr == flash_pkg::OFS_STATUS);
   wire logic known = in_wbuf | (paddr == flash_pkg::OFS_MODE) |
      (paddr == flash_pkg::OFS_CMD) | (paddr == flash_pkg::OFS_STATUS) |
      (paddr == flash_pkg::OFS_RESULT) | (paddr == flash_pkg::OFS_LOCKS) |
      (paddr == flash_pkg::OFS_OPTS) | (paddr == flash_pkg::OFS_MAP) |
      (paddr == flash_pkg::OFS_ACCESS) | (paddr == flash_pkg::OFS_CALIB) |
      (paddr[11:4] == flash_pkg::OFS_UID0[11:4]);

   // ==========================================================
   // command argument decode: page number for program and erase
   wire logic [7:0] cmd_op = op_reg;
   wire logic [10:0] page = arg_reg[10:0];
   wire logic [3:0] region = arg_reg[10:7]; // 128 pages per region
   wire logic page_ok = DUAL_BANK ? ({1'b0, page} < 12'(2 * flash_pkg::PAGES_PER_BANK))
                                  : ({1'b0, page} < 12'(flash_pkg::PAGES_SINGLE));
   wire logic [1:0] nopts = DUAL_BANK ? 2'(flash_pkg::OPT_BITS_DUAL)
                                      : 2'(flash_pkg::OPT_BITS_SINGLE);
   wire logic opt_ok = arg_reg[1:0] < nopts;
   wire logic is_pe = (cmd_op == flash_pkg::CMD_PROG) | (cmd_op == flash_pkg::CMD_ERASE_PAGE);
   wire logic lock_hit = is_pe & locks_reg[region];
   wire logic any_lock = |locks_reg;
   // first 1024 pages are bank 0, next bank 1
   wire logic page_bank = DUAL_BANK & page[10];

   // ==========================================================
   // descriptor words
   logic [31:0] desc_word;
   always_comb begin
      case (desc_idx_reg)
         3'h0: desc_word = DUAL_BANK ? 32'h0000_0002 : 32'h0000_0001;
         3'h1: desc_word = 32'(flash_pkg::PAGE_BYTES);
         3'h2: desc_word = DUAL_BANK ? 32'(flash_pkg::PAGES_PER_BANK)
                                     : 32'(flash_pkg::PAGES_SINGLE);
         3'h3: desc_word = 32'(flash_pkg::WBUF_BYTES);
         3'h4: desc_word = 32'(flash_pkg::LOCK_REGIONS);
         3'h5: desc_word = 32'(flash_pkg::PAGES_PER_REGION);
         default: desc_word = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: if (wr_cmd) state_next = (pwdata[7:0] == flash_pkg::CMD_DESC) ? ST_DESC : ST_EXEC;
         ST_EXEC: state_next = ST_IDLE;
         ST_DESC: if (desc_idx_reg == 3'(flash_pkg::DESC_WORDS - 1)) state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   wire logic exec = state_reg == ST_EXEC;
   wire logic run_ok = exec & ~lock_hit;
   wire logic bad_arg = exec & ((is_pe & ~page_ok) |
      (((cmd_op == flash_pkg::CMD_SET_OPT) | (cmd_op == flash_pkg::CMD_CLR_OPT)) & ~opt_ok));
   wire logic do_set_lock = run_ok & ~bad_arg & (cmd_op == flash_pkg::CMD_SET_LOCK);
   wire logic do_clr_lock = run_ok & ~bad_arg & (cmd_op == flash_pkg::CMD_CLR_LOCK);
   wire logic do_set_opt = run_ok & ~bad_arg & (cmd_op == flash_pkg::CMD_SET_OPT);
   wire logic do_clr_opt = run_ok & ~bad_arg & (cmd_op == flash_pkg::CMD_CLR_OPT) &
      (arg_reg[1:0] != 2'(flash_pkg::OPT_SECURITY)); // security never cleared by the clear-option command
   wire logic do_erase_all = run_ok & (cmd_op == flash_pkg::CMD_ERASE_ALL) & ~any_lock;
   wire logic do_prog = run_ok & ~bad_arg & is_pe;
   wire logic bad_op = exec & ~(is_pe | (cmd_op == flash_pkg::CMD_SET_LOCK) |
      (cmd_op == flash_pkg::CMD_CLR_LOCK) | (cmd_op == flash_pkg::CMD_SET_OPT) |
      (cmd_op == flash_pkg::CMD_CLR_OPT) | (cmd_op == flash_pkg::CMD_ERASE_ALL));
   // full erase with any lock set aborts like a locked page
   wire logic lock_abort = exec & (lock_hit | ((cmd_op == flash_pkg::CMD_ERASE_ALL) & any_lock));

   // ==========================================================
   // option and lock next values
   logic [15:0] locks_next;
   logic [2:0] opts_next;
   always_comb begin
      locks_next = locks_reg;
      opts_next = opts_reg;
      if (do_set_lock) locks_next[arg_reg[3:0]] = 1'b1;
      if (do_clr_lock) locks_next[arg_reg[3:0]] = 1'b0;
      if (do_set_opt) opts_next[arg_reg[1:0]] = 1'b1;
      if (do_clr_opt) opts_next[arg_reg[1:0]] = 1'b0;
      if (do_erase_all && wiped_reg) opts_next[flash_pkg::OPT_SECURITY] = 1'b0;
      if (wipe_pin) begin
         locks_next = flash_pkg::LOCKS_RST;
         opts_next[flash_pkg::OPT_BOOT_FLASH] = 1'b0;
         opts_next[flash_pkg::OPT_BANK_SEL] = 1'b0;
      end
      if (!DUAL_BANK) opts_next[flash_pkg::OPT_BANK_SEL] = 1'b0;
   end

   // ==========================================================
   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         mode_reg <= flash_pkg::MODE_RST[flash_pkg::WS_BITS:0];
         locks_reg <= flash_pkg::LOCKS_RST;
         opts_reg <= flash_pkg::OPTS_RST;
         op_reg <= 8'h00;
         arg_reg <= 16'h0000;
         desc_idx_reg <= 3'h0;
         wiped_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         locks_reg <= locks_next;
         opts_reg <= opts_next;
         if (wr & (paddr == flash_pkg::OFS_MODE))
            mode_reg <= pwdata[flash_pkg::WS_BITS:0];
         if (wr_cmd) begin
            op_reg <= pwdata[7:0];
            arg_reg <= pwdata[23:8];
         end
         desc_idx_reg <= (state_reg == ST_DESC) ? desc_idx_reg + 3'h1 : 3'h0;
         // a wipe arms the security release for the next full erase
         if (wipe_pin) wiped_reg <= 1'b1;
         else if (do_erase_all) wiped_reg <= 1'b0;
      end
   end

   // ==========================================================
   // error flags: set wins over the read that clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_err_reg <= 1'b0;
         cmd_err_reg <= 1'b0;
      end else begin
         lock_err_reg <= lock_abort | (lock_err_reg & ~rd_status);
         cmd_err_reg <= bad_arg | bad_op | (cmd_err_reg & ~rd_status);
      end
   end

   // ==========================================================
   // result word and write buffer; descriptor streams into result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_reg <= 32'h0000_0000;
         prog_bank_reg <= 2'h0;
      end else begin
         if (state_reg == ST_DESC) result_reg <= desc_word;
         // one bank programs per command, never both
         prog_bank_reg <= do_prog ? (page_bank ? 2'b10 : 2'b01) : 2'b00;
      end
   end
   // memory has no reset; software fills it before each program
   always_ff @(posedge pclk) begin
      if (wr & in_wbuf) wbuf[wb_idx] <= pwdata;
   end

   // ==========================================================
   // memory map decode
   wire logic boot_flash = opts_reg[flash_pkg::OPT_BOOT_FLASH];
   wire logic hit_boot = sys_addr < flash_pkg::FLASH_BASE;
   wire logic hit_rom = sys_addr[31:23] == flash_pkg::ROM_BASE[31:23];
   wire logic hit_flash = (sys_addr >= flash_pkg::FLASH_BASE) &
      (sys_addr < flash_pkg::FLASH_BASE + 32'(2 * flash_pkg::BANK_BYTES));
   wire logic hit_sram = (sys_addr >= flash_pkg::SRAM_BASE) & (sys_addr < flash_pkg::BITBAND_LO);
   wire logic hit_band = (sys_addr >= flash_pkg::BITBAND_LO) & (sys_addr <= flash_pkg::BITBAND_HI);
   logic [2:0] target;
   always_comb begin
      target = 3'h0;
      if (hit_boot) target = boot_flash ? 3'h4 : 3'h3;
      else if (hit_rom) target = 3'h3; // rom stays here whatever the boot bit
      else if (hit_flash) target = 3'h4;
      else if (hit_sram) target = 3'h1;
      else if (hit_band) target = 3'h2;
   end

   // ==========================================================
   // bank read arbitration: only one bank read at a time, never the one programming
   wire logic sec = opts_reg[flash_pkg::OPT_SECURITY];
   wire logic [1:0] rd_ok = bank_read_req & ~prog_bank_reg;
   wire logic [1:0] rd_gnt = rd_ok[0] ? 2'b01 : (DUAL_BANK ? {rd_ok[1], 1'b0} : 2'b00);

   // ==========================================================
   // registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         debug_grant <= 1'b0;
         fast_prog_grant <= 1'b0;
         sys_target <= 3'h0;
         bank_read_grant <= 2'b00;
         bank_prog_active <= 2'b00;
         read_width_sel <= 2'b10;
         cmd_done_pulse <= 1'b0;
         lock_abort_pulse <= 1'b0;
      end else begin
         debug_grant <= debug_req & ~sec;
         fast_prog_grant <= fast_prog_req & ~sec;
         sys_target <= target;
         bank_read_grant <= rd_gnt;
         bank_prog_active <= prog_bank_reg;
         read_width_sel <= mode_reg.narrow_read ? 2'b01 : 2'b10;
         cmd_done_pulse <= exec | ((state_reg == ST_DESC) & (state_next == ST_IDLE));
         lock_abort_pulse <= lock_abort;
      end
   end

   // ==========================================================
   // apb read mux; calibration and id are constants, no write reaches them
   flash_pkg::status_s st;
   assign st = '{lock_error: lock_err_reg, cmd_error: cmd_err_reg, busy: busy, ready: ~busy};
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      if (in_wbuf) rmux = wbuf[wb_idx];
      else begin
         case (paddr)
            flash_pkg::OFS_MODE: rmux = 32'(mode_reg);
            flash_pkg::OFS_STATUS: rmux = 32'(st);
            flash_pkg::OFS_RESULT: rmux = result_reg;
            flash_pkg::OFS_LOCKS: rmux = 32'(locks_reg);
            flash_pkg::OFS_OPTS: rmux = 32'(opts_reg);
            flash_pkg::OFS_MAP: rmux = {29'h0, target};
            flash_pkg::OFS_ACCESS: rmux = {30'h0, bank_prog_active};
            flash_pkg::OFS_CALIB: rmux = flash_pkg::CALIB_VAL;
            12'h030: rmux = flash_pkg::UID_VAL[31:0];
            12'h034: rmux = flash_pkg::UID_VAL[63:32];
            12'h038: rmux = flash_pkg::UID_VAL[95:64];
            12'h03c: rmux = flash_pkg::UID_VAL[127:96];
            default: rmux = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // apb answer: one setup plus one access cycle, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & (~known | (pwrite & (paddr == flash_pkg::OFS_CMD) & busy));
         prdata <= (psel & ~penable & ~pwrite) ? rmux : 32'h0000_0000;
      end
   end
endmodule : flash_protect_boot_map

// [inc/flash_pkg.sv]
// package for the flash protection and boot map controller
// assumes an apb slave on pclk; the array is modelled by its organisation only
package flash_pkg;
   // ==========================================================
   // array organisation
   localparam int PAGE_BYTES = 256;
   localparam int PAGES_SINGLE = 2048;
   localparam int PAGES_PER_BANK = 1024;
   localparam int LOCK_REGIONS = 16;
   localparam int PAGES_PER_REGION = 128;
   localparam int WBUF_BYTES = 128;
   localparam int WBUF_WORDS = WBUF_BYTES / 4;
   localparam int BANK_BYTES = 32'h0004_0000; // 256 kbytes per bank
   localparam int OPT_BITS_SINGLE = 2;
   localparam int OPT_BITS_DUAL = 3;
   // ==========================================================
   // option bit positions
   localparam int OPT_SECURITY = 0;
   localparam int OPT_BOOT_FLASH = 1;
   localparam int OPT_BANK_SEL = 2;
   // ==========================================================
   // system memory map
   localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
   localparam logic [31:0] BITBAND_LO = 32'h2200_0000;
   localparam logic [31:0] BITBAND_HI = 32'h23ff_ffff;
   localparam logic [31:0] ROM_BASE = 32'h0080_0000;
   localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;
   localparam logic [31:0] FLASH_BASE = 32'h0040_0000;
   // ==========================================================
   // apb register offsets
   localparam logic [11:0] OFS_MODE = 12'h000;
   localparam logic [11:0] OFS_CMD = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_RESULT = 12'h00c;
   localparam logic [11:0] OFS_LOCKS = 12'h010;
   localparam logic [11:0] OFS_OPTS = 12'h014;
   localparam logic [11:0] OFS_MAP = 12'h018;
   localparam logic [11:0] OFS_ACCESS = 12'h01c;
   localparam logic [11:0] OFS_CALIB = 12'h020;
   localparam logic [11:0] OFS_UID0 = 12'h030;
   localparam logic [11:0] OFS_WBUF = 12'h100;
   // ==========================================================
   // reset values and factory constants (values arbitrary)
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [2:0] OPTS_RST = 3'h0;
   localparam logic [15:0] LOCKS_RST = 16'h0000;
   localparam logic [31:0] CALIB_VAL = 32'h0000_5a5a;
   localparam logic [127:0] UID_VAL = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978;
   localparam int WS_BITS = 4;
   // ==========================================================
   // command opcodes, argument in cmd[23:8]
   typedef enum logic [7:0] {
      CMD_DESC = 8'h00, CMD_PROG = 8'h01, CMD_ERASE_PAGE = 8'h02, CMD_ERASE_ALL = 8'h05,
      CMD_SET_LOCK = 8'h08, CMD_CLR_LOCK = 8'h09, CMD_SET_OPT = 8'h0b, CMD_CLR_OPT = 8'h0c
   } cmd_e;
   // descriptor word count
   localparam int DESC_WORDS = 6;
   // ==========================================================
   typedef struct packed {
      logic lock_error;
      logic cmd_error;
      logic busy;
      logic ready;
   } status_s;
   typedef struct packed {
      logic [WS_BITS-1:0] wait_states;
      logic narrow_read; // 1: 64-bit array reads
   } mode_s;
endpackage : flash_pkg

// [dv/flash_protect_boot_map_asserts.sv]
// concurrent checks on the ports of the flash boot map block
// assumes one pclk domain with presetn async active low, bound from the bench top
// ==========================================================
module flash_protect_boot_map_asserts (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // external access
   input wire logic debug_req,
   input wire logic debug_grant,
   input wire logic fast_prog_req,
   input wire logic fast_prog_grant,
   input wire logic [31:0] sys_addr,
   input wire logic [2:0] sys_target,
   // array side
   input wire logic [1:0] bank_read_grant,
   input wire logic [1:0] bank_prog_active,
   input wire logic [1:0] read_width_sel,
   input wire logic cmd_done_pulse,
   input wire logic lock_abort_pulse
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // bus handshake steps
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_one_pulse;
      pready ##1 !pready;
   endsequence
   // answer one cycle after setup, for one cycle
   property p_ready_after_setup;
      s_setup |=> s_one_pulse;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup)
      else $error("pready not a pulse after setup");
   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("pslverr seen without pready");
   // no grant without a request the cycle before
   property p_debug_grant;
      !debug_req |=> !debug_grant;
   endproperty
   a_debug_grant: assert property (p_debug_grant)
      else $error("debug grant without request");
   property p_fast_grant;
      fast_prog_grant |-> $past(fast_prog_req);
   endproperty
   a_fast_grant: assert property (p_fast_grant)
      else $error("fast grant without request");
   // fixed windows of the memory map
   property p_sram_map;
      sys_addr == flash_pkg::SRAM_BASE |=> sys_target == 3'h1;
   endproperty
   a_sram_map: assert property (p_sram_map)
      else $error("sram base not decoded");
   property p_bitband_map;
      sys_addr inside {[flash_pkg::BITBAND_LO:flash_pkg::BITBAND_HI]} |=> sys_target == 3'h2;
   endproperty
   a_bitband_map: assert property (p_bitband_map)
      else $error("bit-band alias not decoded");
   property p_rom_map;
      sys_addr == flash_pkg::ROM_BASE |=> sys_target == 3'h3;
   endproperty
   a_rom_map: assert property (p_rom_map)
      else $error("rom base not decoded");
   // never both banks read or programmed, never read a busy bank
   property p_bank_excl;
      bank_read_grant != 2'b11 && bank_prog_active != 2'b11
         && (bank_read_grant & bank_prog_active) == 2'b00;
   endproperty
   a_bank_excl: assert property (p_bank_excl)
      else $error("bank access overlap");
   property p_width_onehot;
      $onehot(read_width_sel);
   endproperty
   a_width_onehot: assert property (p_width_onehot)
      else $error("read width select not one-hot");
   // an abort ends the command, and lasts a single cycle
   property p_abort_ends_cmd;
      lock_abort_pulse |-> cmd_done_pulse ##1 !lock_abort_pulse;
   endproperty
   a_abort_ends_cmd: assert property (p_abort_ends_cmd)
      else $error("abort without command end");
endmodule : flash_protect_boot_map_asserts

// [dv/wipe_driver.sv]
// partner model of the party that drives the wipe pin
// assumes a one-cycle go request from the bench, on pclk
// ==========================================================
module wipe_driver #(
   parameter int HOLD = 40 // stands in for the long hold, shortened for run time
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control and pin
   input wire logic go,
   output logic wipe_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_reg;
   // holds the pin for the full span whatever the bench does meanwhile
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 0;
         wipe_pin <= 1'b0;
      end else if (go) begin
         cnt_reg <= HOLD;
         wipe_pin <= 1'b1;
      end else if (cnt_reg > 0) begin
         cnt_reg <= cnt_reg - 1;
         wipe_pin <= (cnt_reg > 1);
      end
   end
endmodule : wipe_driver

// [dv/flash_protect_boot_map_tb.sv]
// self-checking bench for the flash boot map block
// assumes the designer's zero-wait apb timing and command pulses
// ==========================================================
module flash_protect_boot_map_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wipe_pin, wipe_go;
   logic debug_req, fast_prog_req, debug_grant, fast_prog_grant, cmd_done_pulse;
   logic lock_abort_pulse, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, sys_addr, rd;
   logic [1:0] bank_read_req, bank_read_grant, bank_prog_active, read_width_sel;
   logic [2:0] sys_target;
   int err_total, checks_done, abort_cnt, a0;
   flash_protect_boot_map #(.DUAL_BANK(1'b1)) flash_protect_boot_map_inst (.*);
   wipe_driver wipe_driver_inst (
      .pclk(pclk), .presetn(presetn), .go(wipe_go), .wipe_pin(wipe_pin));
   // ==========================================================
   // clock and abort counter
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) if (lock_abort_pulse === 1'b1) abort_cnt <= abort_cnt + 1;
   // ==========================================================
   // closing task and shared bus cycles
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // holds the request until pready is sampled high; the watchdog bounds the wait
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, exp, rd);
   endtask : rdchk
   // waits for the end pulse, then one edge for the counters
   task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
      apb(1'b1, flash_pkg::OFS_CMD, {8'h00, arg, op});
      while (cmd_done_pulse !== 1'b1) @(posedge pclk);
      @(posedge pclk);
   endtask : cmd
   task automatic map(input logic [31:0] a, input logic [2:0] exp);
      @(posedge pclk) sys_addr <= a;
      repeat (3) @(posedge pclk);
      chk("sys_target", {29'h0, exp}, {29'h0, sys_target});
   endtask : map
   task automatic settle();
      repeat (3) @(posedge pclk);
   endtask : settle
   // ==========================================================
   // test sequence
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; wipe_go = 1'b0; debug_req = 1'b0; fast_prog_req = 1'b0;
      sys_addr = 32'h0; bank_read_req = 2'b00; err_total = 0; checks_done = 0; abort_cnt = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("locks", flash_pkg::OFS_LOCKS, 32'h0000_0000);
      rdchk("opts", flash_pkg::OFS_OPTS, 32'h0000_0000);
      chk("width", 32'h0000_0002, {30'h0, read_width_sel});
      apb(1'b1, flash_pkg::OFS_CALIB, 32'h0000_0000);
      rdchk("calib", flash_pkg::OFS_CALIB, flash_pkg::CALIB_VAL);
      apb(1'b1, flash_pkg::OFS_MODE, 32'h0000_0001);
      settle();
      chk("width", 32'h0000_0001, {30'h0, read_width_sel});
      apb(1'b1, flash_pkg::OFS_MODE, 32'h0000_0000);
      apb(1'b0, 12'h0fc, 32'h0000_0000);
      chk("unmapped err", 32'h0000_0001, {31'h0, er});
      apb(1'b1, flash_pkg::OFS_WBUF + 12'h07c, 32'hcafe_0001);
      chk("wbuf last word err", 32'h0000_0000, {31'h0, er});
      $display("test registers done");
      cmd(flash_pkg::CMD_SET_LOCK, 16'h0003);
      rdchk("locks", flash_pkg::OFS_LOCKS, 32'h0000_0008);
      a0 = abort_cnt;
      cmd(flash_pkg::CMD_PROG, 16'd384);
      chk("abort", 32'h0000_0001, abort_cnt - a0);
      rdchk("status", flash_pkg::OFS_STATUS, 32'h0000_0009);
      rdchk("status", flash_pkg::OFS_STATUS, 32'h0000_0001);
      cmd(flash_pkg::CMD_PROG, 16'd383);
      cmd(flash_pkg::CMD_SET_LOCK, 16'h000f);
      cmd(flash_pkg::CMD_ERASE_PAGE, 16'd2047);
      chk("abort", 32'h0000_0002, abort_cnt - a0);
      cmd(flash_pkg::CMD_CLR_LOCK, 16'h0003);
      rdchk("locks", flash_pkg::OFS_LOCKS, 32'h0000_8000);
      $display("test locks done");
      map(flash_pkg::SRAM_BASE, 3'h1);
      map(flash_pkg::BITBAND_HI, 3'h2);
      map(flash_pkg::ROM_BASE, 3'h3);
      map(flash_pkg::BOOT_ADDR, 3'h3);
      cmd(flash_pkg::CMD_SET_OPT, 16'h0001);
      map(flash_pkg::BOOT_ADDR, 3'h4);
      cmd(flash_pkg::CMD_SET_OPT, 16'h0002);
      rdchk("opts", flash_pkg::OFS_OPTS, 32'h0000_0006);
      debug_req <= 1'b1;
      fast_prog_req <= 1'b1;
      settle();
      chk("debug grant", 32'h0000_0001, {31'h0, debug_grant});
      cmd(flash_pkg::CMD_SET_OPT, 16'h0000);
      cmd(flash_pkg::CMD_CLR_OPT, 16'h0000);
      rdchk("opts", flash_pkg::OFS_OPTS, 32'h0000_0007);
      chk("debug grant", 32'h0000_0000, {31'h0, debug_grant});
      chk("fast grant", 32'h0000_0000, {31'h0, fast_prog_grant});
      $display("test options done");
      @(posedge pclk) wipe_go <= 1'b1;
      @(posedge pclk) wipe_go <= 1'b0;
      repeat (50) @(posedge pclk);
      rdchk("locks", flash_pkg::OFS_LOCKS, 32'h0000_0000);
      rdchk("opts", flash_pkg::OFS_OPTS, 32'h0000_0001);
      rdchk("calib", flash_pkg::OFS_CALIB, flash_pkg::CALIB_VAL);
      map(flash_pkg::BOOT_ADDR, 3'h3);
      chk("debug grant", 32'h0000_0000, {31'h0, debug_grant});
      cmd(flash_pkg::CMD_ERASE_ALL, 16'h0000);
      rdchk("opts", flash_pkg::OFS_OPTS, 32'h0000_0000);
      settle();
      chk("debug grant", 32'h0000_0001, {31'h0, debug_grant});
      $display("test wipe done");
      bank_read_req <= 2'b11;
      settle();
      chk("bank grant", 32'h0000_0001, {30'h0, bank_read_grant});
      bank_read_req <= 2'b10;
      settle();
      chk("bank grant", 32'h0000_0002, {30'h0, bank_read_grant});
      apb(1'b1, flash_pkg::OFS_CMD, {24'h0, flash_pkg::CMD_DESC});
      apb(1'b1, flash_pkg::OFS_CMD, {8'h00, 16'h0000, flash_pkg::CMD_SET_LOCK});
      chk("busy refusal", 32'h0000_0001, {31'h0, er});
      repeat (10) @(posedge pclk);
      rdchk("result", flash_pkg::OFS_RESULT, flash_pkg::PAGES_PER_REGION);
      rdchk("locks", flash_pkg::OFS_LOCKS, 32'h0000_0000);
      $display("test banks done");
      end_sim();
   end
   // watchdog well past the few hundred cycles the tests need
   initial begin
      #200000;
      err_total++;
      end_sim();
   end
endmodule : flash_protect_boot_map_tb
bind flash_protect_boot_map flash_protect_boot_map_asserts flash_protect_boot_map_asserts_inst (.*);
